// file: pld_pkg.sv
// constants, types and helpers shared by the macrocell register block
// assumes a 100 MHz pclk and an 8-bit APB byte address
package pld_pkg;

    localparam int N_IN = 12;
    localparam int N_MC = 10;

    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_POLARITY = 8'h04;
    localparam logic [7:0] OFF_REGSEL = 8'h08;
    localparam logic [7:0] OFF_PRELOAD = 8'h0c;
    localparam logic [7:0] OFF_SIG_LO = 8'h10;
    localparam logic [7:0] OFF_SIG_HI = 8'h14;
    localparam logic [7:0] OFF_STATUS = 8'h18;
    localparam logic [7:0] OFF_VERIFY = 8'h1c;

    // field positions
    localparam int CTRL_SECURE_BIT = 0;
    localparam int PRELOAD_MASK_LSB = 16;
    localparam int VERIFY_REGSEL_LSB = 16;
    localparam int STATUS_SECURE_BIT = 16;
    localparam int STATUS_POR_BIT = 17;

    // reset values
    localparam logic [9:0] RST_POLARITY = 10'h000;
    localparam logic [9:0] RST_REGSEL = 10'h000;
    localparam logic [63:0] RST_SIG = 64'h0000_0000_0000_0000;

    // power-up reset interval, longest time rounds down to whole cycles
    localparam int PUR_INTERVAL_TYP_NS = 600;
    localparam int PUR_INTERVAL_MAX_NS = 1000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int POR_CYCLES = (PUR_INTERVAL_MAX_NS / CLK_PERIOD_NS < 1) ? 1 :
                                PUR_INTERVAL_MAX_NS / CLK_PERIOD_NS;
    localparam int POR_CNT_W = 8;

    typedef enum logic [1:0] {
        POR_HOLD = 2'b01,
        POR_RUN = 2'b10
    } por_state_t;

    function automatic logic addr_mapped(input logic [7:0] a);
        return (a == OFF_CTRL) || (a == OFF_POLARITY) || (a == OFF_REGSEL) ||
               (a == OFF_PRELOAD) || (a == OFF_SIG_LO) || (a == OFF_SIG_HI) ||
               (a == OFF_STATUS) || (a == OFF_VERIFY);
    endfunction : addr_mapped

    // access that the security bit refuses
    function automatic logic addr_secured(input logic [7:0] a);
        return (a == OFF_PRELOAD) || (a == OFF_VERIFY);
    endfunction : addr_secured

endpackage : pld_pkg

// file: pin_keeper.sv
// bank of pin keepers: holds the last driven level of undriven pins
// assumes the pad value and a per-pin driven flag are synchronous to pclk
`timescale 1ns/10ps
`default_nettype none

module pin_keeper #(
    parameter int W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] pad_val,
    input wire logic [W-1:0] pad_driven,
    output logic [W-1:0] level
);

    logic [W-1:0] level_ff;
    logic [W-1:0] nxt_level;

    always_comb
    begin
        // a driven pin always wins over the weak hold
        nxt_level = (pad_driven & pad_val) | (~pad_driven & level_ff);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            level_ff <= '0;
        end
        else
        begin
            level_ff <= nxt_level;
        end
    end

    assign level = level_ff;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // the edge that releases reset still runs the flops in reset, so start one later
    a_keeper_holds_level: assert property (
        presetn |=> ((~$past(pad_driven) & (level ^ $past(level))) == '0))
        else $error("undriven pin changed its held level");
    a_driver_overrides: assert property (
        presetn |=> (($past(pad_driven) & (level ^ $past(pad_val))) == '0))
        else $error("driven pin level not taken");

endmodule : pin_keeper

`default_nettype wire

// file: macrocell_bank.sv
// ten output macrocells: register, preload, polarity and path select
// assumes sum and enable terms come from an external product-term array
`timescale 1ns/10ps
`default_nettype none

module macrocell_bank (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clear,
    input wire logic [9:0] pl_mask,
    input wire logic [9:0] pl_data,
    input wire logic [9:0] sum_term,
    input wire logic [9:0] oe_term,
    input wire logic [9:0] polarity,
    input wire logic [9:0] regsel,
    output logic [9:0] io_out,
    output logic [9:0] io_oe,
    output logic [9:0] feedback
);

    logic [9:0] mc_ff, nxt_mc;
    logic [9:0] pin_ff, nxt_pin;
    logic [9:0] oe_ff, nxt_oe;
    logic [9:0] fb_ff, nxt_fb;

    always_comb
    begin
        if (clear)
        begin
            nxt_mc = '0;
        end
        else
        begin
            // preload overrides the array for the selected cells only
            nxt_mc = (pl_mask & pl_data) | (~pl_mask & sum_term);
        end
        // four output forms: polarity over registered or combinational path
        nxt_pin = polarity ^ ((regsel & nxt_mc) | (~regsel & sum_term));
        nxt_fb = (regsel & nxt_mc) | (~regsel & sum_term);
        nxt_oe = oe_term;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mc_ff <= '0;
            pin_ff <= '0;
            oe_ff <= '0;
            fb_ff <= '0;
        end
        else
        begin
            mc_ff <= nxt_mc;
            pin_ff <= nxt_pin;
            oe_ff <= nxt_oe;
            fb_ff <= nxt_fb;
        end
    end

    assign io_out = pin_ff;
    assign io_oe = oe_ff;
    assign feedback = fb_ff;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_clear_zeroes_regs: assert property (
        clear |=> (mc_ff == '0))
        else $error("macrocell register not cleared during power-up reset");
    a_reset_pin_polarity: assert property (
        clear |=> ((io_out & $past(regsel)) == ($past(polarity) & $past(regsel))))
        else $error("registered pin not at polarity level after clear");
    a_preload_forces: assert property (
        (!clear && pl_mask != '0) |=> (((mc_ff ^ $past(pl_data)) & $past(pl_mask)) == '0))
        else $error("preload value not loaded");
    a_capture_edge: assert property (
        (!clear && pl_mask == '0) |=> (mc_ff == $past(sum_term)))
        else $error("registered cell did not capture its sum term");
    // not from the release edge: the flops still sit in reset there
    a_output_form: assert property (
        presetn |=> (io_out == ($past(polarity) ^ (($past(regsel) & mc_ff) |
                                                 (~$past(regsel) & $past(sum_term))))))
        else $error("pin does not follow the configured output form");

    c_preload_seen: cover property (!clear && pl_mask != '0);

endmodule : macrocell_bank

`default_nettype wire

// file: pld_regctl.sv
// register side of a 12-input, 10-macrocell programmable logic device
// assumes an APB master on pclk; presetn stands for the supply power-up reset
//
// Operation
// - macrocell registers clear during the power-up reset interval after supply threshold
// - after reset each registered pin shows its polarity applied to the cleared register
// - each macrocell register can be preloaded high or low individually
// - 64-bit user signature is always writable and readable, secured or not
// - security bit blocks fuse verify and preload at once
// - undriven input and io pins hold their last driven level
// - an external driver always overrides the held pin level
// - twelve dedicated inputs and ten bidirectional macrocells, one pin each
// - each macrocell picks polarity and registered or combinational path
//
// Chosen here: the register offsets and the APB register port.
`timescale 1ns/10ps
`default_nettype none

module pld_regctl (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [11:0] in_val,
    input wire logic [11:0] in_driven,
    output logic [11:0] in_level,
    input wire logic [9:0] io_in,
    input wire logic [9:0] io_ext_driven,
    output logic [9:0] io_out,
    output logic [9:0] io_oe,
    output logic [9:0] io_level,
    input wire logic [9:0] sum_term,
    input wire logic [9:0] oe_term,
    output logic [9:0] feedback
);

    // ************************************************************
    // power-up reset interval
    // ************************************************************
    pld_pkg::por_state_t por_state_ff, nxt_por_state;
    logic [pld_pkg::POR_CNT_W-1:0] por_cnt_ff, nxt_por_cnt;
    logic por_busy;

    localparam logic [pld_pkg::POR_CNT_W-1:0] POR_LAST =
        pld_pkg::POR_CNT_W'(pld_pkg::POR_CYCLES - 1);

    always_comb
    begin
        nxt_por_state = por_state_ff;
        nxt_por_cnt = por_cnt_ff;
        unique case (por_state_ff)
            pld_pkg::POR_HOLD:
            begin
                // registers stay clear while the clock is assumed quiet
                if (por_cnt_ff == POR_LAST)
                begin
                    nxt_por_state = pld_pkg::POR_RUN;
                end
                else
                begin
                    nxt_por_cnt = por_cnt_ff + 1'b1;
                end
            end
            pld_pkg::POR_RUN:
            begin
                nxt_por_state = pld_pkg::POR_RUN;
            end
            default:
            begin
                nxt_por_state = pld_pkg::POR_HOLD;
                nxt_por_cnt = '0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            por_state_ff <= pld_pkg::POR_HOLD;
            por_cnt_ff <= '0;
        end
        else
        begin
            por_state_ff <= nxt_por_state;
            por_cnt_ff <= nxt_por_cnt;
        end
    end

    assign por_busy = (por_state_ff != pld_pkg::POR_RUN);

    // ************************************************************
    // apb slave and configuration registers
    // ************************************************************
    logic [9:0] polarity_ff, nxt_polarity;
    logic [9:0] regsel_ff, nxt_regsel;
    logic [63:0] sig_ff, nxt_sig;
    logic secure_ff, nxt_secure;
    logic [31:0] prdata_ff, nxt_prdata;
    logic pready_ff, nxt_pready;
    logic pslverr_ff, nxt_pslverr;
    logic setup_phase;
    logic wr_fire;
    logic refused;
    logic [9:0] pl_mask;
    logic [9:0] pl_data;

    assign setup_phase = psel && !penable;
    assign wr_fire = psel && penable && pready_ff && pwrite && !pslverr_ff;

    // preload and verify are refused while secured, and while the power-up clear runs
    assign refused = pld_pkg::addr_secured(paddr) && (secure_ff || por_busy);

    always_comb
    begin
        nxt_pready = setup_phase;
        nxt_pslverr = 1'b0;
        nxt_prdata = '0;
        if (setup_phase)
        begin
            if (!pld_pkg::addr_mapped(paddr) || refused)
            begin
                nxt_pslverr = 1'b1;
            end
            else if (!pwrite)
            begin
                unique case (paddr)
                    pld_pkg::OFF_CTRL:
                        nxt_prdata[pld_pkg::CTRL_SECURE_BIT] = secure_ff;
                    pld_pkg::OFF_POLARITY:
                        nxt_prdata[9:0] = polarity_ff;
                    pld_pkg::OFF_REGSEL:
                        nxt_prdata[9:0] = regsel_ff;
                    pld_pkg::OFF_SIG_LO:
                        nxt_prdata = sig_ff[31:0];
                    pld_pkg::OFF_SIG_HI:
                        nxt_prdata = sig_ff[63:32];
                    pld_pkg::OFF_STATUS:
                    begin
                        nxt_prdata[9:0] = feedback;
                        nxt_prdata[pld_pkg::STATUS_SECURE_BIT] = secure_ff;
                        nxt_prdata[pld_pkg::STATUS_POR_BIT] = por_busy;
                    end
                    pld_pkg::OFF_VERIFY:
                    begin
                        // fuse verify: configuration as programmed
                        nxt_prdata[9:0] = polarity_ff;
                        nxt_prdata[pld_pkg::VERIFY_REGSEL_LSB +: 10] = regsel_ff;
                    end
                    default:
                        nxt_prdata = '0;
                endcase
            end
        end
    end

    always_comb
    begin
        nxt_polarity = polarity_ff;
        nxt_regsel = regsel_ff;
        nxt_sig = sig_ff;
        nxt_secure = secure_ff;
        pl_mask = '0;
        pl_data = '0;
        if (wr_fire)
        begin
            unique case (paddr)
                pld_pkg::OFF_CTRL:
                    // set-only: once secured only a power cycle clears it
                    nxt_secure = secure_ff | pwdata[pld_pkg::CTRL_SECURE_BIT];
                pld_pkg::OFF_POLARITY:
                    nxt_polarity = pwdata[9:0];
                pld_pkg::OFF_REGSEL:
                    nxt_regsel = pwdata[9:0];
                pld_pkg::OFF_PRELOAD:
                begin
                    pl_mask = pwdata[pld_pkg::PRELOAD_MASK_LSB +: 10];
                    pl_data = pwdata[9:0];
                end
                pld_pkg::OFF_SIG_LO:
                    nxt_sig[31:0] = pwdata;
                pld_pkg::OFF_SIG_HI:
                    nxt_sig[63:32] = pwdata;
                default:
                begin
                    nxt_secure = secure_ff;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            polarity_ff <= pld_pkg::RST_POLARITY;
            regsel_ff <= pld_pkg::RST_REGSEL;
            sig_ff <= pld_pkg::RST_SIG;
            secure_ff <= 1'b0;
            prdata_ff <= '0;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end
        else
        begin
            polarity_ff <= nxt_polarity;
            regsel_ff <= nxt_regsel;
            sig_ff <= nxt_sig;
            secure_ff <= nxt_secure;
            prdata_ff <= nxt_prdata;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;

    // ************************************************************
    // macrocells and pin keepers
    // ************************************************************
    macrocell_bank u_cells (
        .pclk(pclk),
        .presetn(presetn),
        .clear(por_busy),
        .pl_mask(pl_mask),
        .pl_data(pl_data),
        .sum_term(sum_term),
        .oe_term(oe_term),
        .polarity(polarity_ff),
        .regsel(regsel_ff),
        .io_out(io_out),
        .io_oe(io_oe),
        .feedback(feedback)
    );

    pin_keeper #(.W(pld_pkg::N_IN)) u_in_keep (
        .pclk(pclk),
        .presetn(presetn),
        .pad_val(in_val),
        .pad_driven(in_driven),
        .level(in_level)
    );

    // an io pin counts as driven by us or by the board
    pin_keeper #(.W(pld_pkg::N_MC)) u_io_keep (
        .pclk(pclk),
        .presetn(presetn),
        .pad_val(io_in),
        .pad_driven(io_ext_driven | io_oe),
        .level(io_level)
    );

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_secure_refuses: assert property (
        (setup_phase && secure_ff && pld_pkg::addr_secured(paddr)) |=> (pready && pslverr))
        else $error("secured preload or verify not refused");
    a_secure_no_preload: assert property (
        secure_ff |-> (pl_mask == '0))
        else $error("preload reached the cells while secured");
    a_secure_sticky: assert property (
        secure_ff |=> secure_ff)
        else $error("security bit cleared without power cycle");
    a_sig_write_lo: assert property (
        (wr_fire && paddr == pld_pkg::OFF_SIG_LO) |=> (sig_ff[31:0] == $past(pwdata)))
        else $error("signature low word not stored");
    a_sig_read_ok: assert property (
        (setup_phase && !pwrite && paddr == pld_pkg::OFF_SIG_HI)
        |=> (!pslverr && prdata == sig_ff[63:32]))
        else $error("signature read refused or wrong");
    a_por_bounded: assert property (
        por_busy |-> (por_cnt_ff <= POR_LAST))
        else $error("power-up reset interval overran");
    a_por_ends: assert property (
        (por_busy && por_cnt_ff == POR_LAST) |=> !por_busy)
        else $error("power-up reset interval did not end");

    c_secure_set: cover property ($rose(secure_ff));
    c_por_done: cover property ($fell(por_busy));
    c_refused_access: cover property (pready && pslverr && secure_ff);

endmodule : pld_regctl

`default_nettype wire

// file: board_model.sv
// board-side pad model: drivers for the dedicated inputs and the io pins
// assumes the bench sets drive values and enables just after rising pclk
`timescale 1ns/10ps
`default_nettype none

// ************************************************************
// pad drivers
// ************************************************************
module board_model (
    input wire logic pclk,
    input wire logic [11:0] in_req,
    input wire logic [11:0] in_en,
    input wire logic [9:0] io_req,
    input wire logic [9:0] io_en,
    input wire logic [9:0] io_out,
    input wire logic [9:0] io_oe,
    output logic [11:0] in_val,
    output logic [11:0] in_driven,
    output logic [9:0] io_in,
    output logic [9:0] io_ext_driven
);
    logic [11:0] last_in_ff = 12'h000;
    logic [9:0] last_io_ff = 10'h000;
    logic [9:0] io_drv;

    // a released pad shows the inverse of its last level, so a keeper cannot pass by luck
    assign in_driven = in_en;
    assign in_val = (in_en & in_req) | (~in_en & ~last_in_ff);
    // the device wins a contention; the bench never drives while io_oe is high
    assign io_ext_driven = io_en & ~io_oe;
    assign io_drv = io_oe | io_en;
    assign io_in = (io_oe & io_out) | (io_ext_driven & io_req) | (~io_drv & ~last_io_ff);

    always @(posedge pclk)
    begin
        last_in_ff <= (in_en & in_req) | (~in_en & last_in_ff);
        last_io_ff <= (io_drv & io_in) | (~io_drv & last_io_ff);
    end
endmodule : board_model

`default_nettype wire

// file: test_pld_regctl.sv
// self-checking bench for the macrocell register block
// assumes board_model on the pad side; apb is mastered from here
`timescale 1ns/10ps
`default_nettype none

module test_pld_regctl;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [11:0] in_req, in_en, in_val, in_driven, in_level;
    logic [9:0] io_req, io_en, io_in, io_ext_driven, io_out, io_oe, io_level;
    logic [9:0] sum_term, oe_term, feedback;
    logic [9:0] sv [3];
    int miscompares = 0;
    int n_tests = 0;
    int cyc = 0;
    int rel = 0;
    typedef struct {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] x; logic e;} row_t;
    row_t rows [15];

    pld_regctl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .in_val(in_val), .in_driven(in_driven), .in_level(in_level),
        .io_in(io_in), .io_ext_driven(io_ext_driven), .io_out(io_out), .io_oe(io_oe),
        .io_level(io_level), .sum_term(sum_term), .oe_term(oe_term), .feedback(feedback));

    board_model board_u (.pclk(pclk), .in_req(in_req), .in_en(in_en), .io_req(io_req),
        .io_en(io_en), .io_out(io_out), .io_oe(io_oe), .in_val(in_val),
        .in_driven(in_driven), .io_in(io_in), .io_ext_driven(io_ext_driven));

    // ************************************************************
    // clock, timeout and shared tasks
    // ************************************************************
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            miscompares++;
            $display("CHECK FAILED timeout expected done seen running");
            finish_test();
        end
    end

    task automatic chk_word(input string nm, input logic [31:0] x, input logic [31:0] got);
        n_tests++;
        if (got !== x)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, x, got);
        end
    endtask : chk_word

    task automatic chk_pins(input string nm, input logic [9:0] x, input logic [9:0] got);
        chk_word(nm, {22'h0, x}, {22'h0, got});
    endtask : chk_pins

    task automatic chk_flag(input string nm, input logic x, input logic got);
        chk_word(nm, {31'h0, x}, {31'h0, got});
    endtask : chk_flag

    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // the slave answers with no wait states
        chk_word("access cycles", 32'h0000_0001, n);
    endtask : apb

    task automatic acc(input logic [7:0] a, input logic w, input logic [31:0] d,
                       input logic [31:0] x, input logic e, input string nm);
        apb(a, w, d);
        if (!w)
            chk_word(nm, x, rd);
        chk_flag(nm, e, er);
    endtask : acc

    task automatic wait_to(input int c);
        while (cyc < c)
            @(posedge pclk);
        #1;
    endtask : wait_to

    task automatic finish_test();
        $display("checks %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test

    // ************************************************************
    // main sequence
    // ************************************************************
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {in_req, in_en, io_req, io_en, sum_term, oe_term} = '0;
        sv = '{10'h000, 10'h3ff, 10'h2b6};
        rows = '{
            '{pld_pkg::OFF_SIG_LO, 1'b1, 32'h89ab_cdef, 32'h0, 1'b0},
            '{pld_pkg::OFF_SIG_LO, 1'b0, 32'h0, 32'h89ab_cdef, 1'b0},
            '{pld_pkg::OFF_SIG_HI, 1'b1, 32'h0123_4567, 32'h0, 1'b0},
            '{pld_pkg::OFF_SIG_HI, 1'b0, 32'h0, 32'h0123_4567, 1'b0},
            '{pld_pkg::OFF_POLARITY, 1'b1, 32'hffff_f0a5, 32'h0, 1'b0},
            '{pld_pkg::OFF_POLARITY, 1'b0, 32'h0, 32'h0000_00a5, 1'b0},
            '{pld_pkg::OFF_REGSEL, 1'b1, 32'h0000_00cc, 32'h0, 1'b0},
            '{pld_pkg::OFF_REGSEL, 1'b0, 32'h0, 32'h0000_00cc, 1'b0},
            '{pld_pkg::OFF_VERIFY, 1'b1, 32'hffff_ffff, 32'h0, 1'b0},
            '{pld_pkg::OFF_VERIFY, 1'b0, 32'h0, 32'h00cc_00a5, 1'b0},
            '{pld_pkg::OFF_PRELOAD, 1'b0, 32'h0, 32'h0, 1'b0},
            '{pld_pkg::OFF_STATUS, 1'b1, 32'hffff_ffff, 32'h0, 1'b0},
            '{pld_pkg::OFF_STATUS, 1'b0, 32'h0, 32'h0000_03ff, 1'b0},
            '{8'h20, 1'b1, 32'h1, 32'h0, 1'b1},
            '{8'h20, 1'b0, 32'h0, 32'h0, 1'b1}};
        repeat (20) @(posedge pclk);
        #1;
        chk_pins("io_out in reset", 10'h000, io_out);
        chk_flag("pready in reset", 1'b0, pready);
        @(posedge pclk);
        presetn <= 1'b1;
        rel = cyc;
        acc(pld_pkg::OFF_STATUS, 1'b0, 32'h0, 32'h0002_0000, 1'b0, "status busy");
        acc(pld_pkg::OFF_PRELOAD, 1'b1, 32'h03ff_03ff, 32'h0, 1'b1, "clear preload");
        acc(pld_pkg::OFF_REGSEL, 1'b1, 32'h3ff, 32'h0, 1'b0, "regsel all");
        @(posedge pclk);
        sum_term <= 10'h3ff;
        wait_to(rel + 90);
        chk_pins("feedback cleared", 10'h000, feedback);
        chk_pins("io_out cleared", 10'h000, io_out);
        acc(pld_pkg::OFF_STATUS, 1'b0, 32'h0, 32'h0002_0000, 1'b0, "status late");
        wait_to(rel + 110);
        chk_pins("feedback running", 10'h3ff, feedback);
        $display("test power_up done");
        for (int i = 0; i < 15; i++)
            acc(rows[i].a, rows[i].w, rows[i].d, rows[i].x, rows[i].e, "row");
        $display("test register_table done");
        for (int i = 0; i < 3; i++)
        begin
            @(posedge pclk);
            sum_term <= sv[i];
            oe_term <= sv[i];
            repeat (2) @(posedge pclk);
            #1;
            chk_pins("io_out form", sv[i] ^ 10'h0a5, io_out);
            chk_pins("feedback form", sv[i], feedback);
            chk_pins("io_oe", sv[i], io_oe);
        end
        $display("test output_forms done");
        acc(pld_pkg::OFF_REGSEL, 1'b1, 32'h3ff, 32'h0, 1'b0, "regsel all");
        @(posedge pclk);
        sum_term <= 10'h0f0;
        oe_term <= 10'h000;
        // mask 0x03f forces bits 0 and 2 high and bit 5 low against the array
        acc(pld_pkg::OFF_PRELOAD, 1'b1, 32'h003f_0015, 32'h0, 1'b0, "preload");
        #1;
        chk_pins("preloaded", 10'h0d5, feedback);
        chk_pins("preloaded pin", 10'h070, io_out);
        @(posedge pclk);
        #1;
        chk_pins("after preload", 10'h0f0, feedback);
        $display("test preload done");
        @(posedge pclk);
        in_req <= 12'ha5c;
        in_en <= 12'hfff;
        io_req <= 10'h2d3;
        io_en <= 10'h3ff;
        repeat (2) @(posedge pclk);
        #1;
        chk_word("in_level", 32'h0000_0a5c, {20'h0, in_level});
        chk_pins("io_level", 10'h2d3, io_level);
        @(posedge pclk);
        in_req <= 12'h3c3;
        in_en <= 12'h0ff;
        io_req <= 10'h10c;
        io_en <= 10'h00f;
        repeat (3) @(posedge pclk);
        #1;
        chk_word("in_level held", 32'h0000_0ac3, {20'h0, in_level});
        chk_pins("io_level held", 10'h2dc, io_level);
        $display("test keepers done");
        // securing comes after all configuration, as a programmer would do it
        acc(pld_pkg::OFF_CTRL, 1'b1, 32'h1, 32'h0, 1'b0, "secure");
        acc(pld_pkg::OFF_PRELOAD, 1'b1, 32'h03ff_03ff, 32'h0, 1'b1, "preload secured");
        #1;
        chk_pins("no preload", 10'h0f0, feedback);
        acc(pld_pkg::OFF_VERIFY, 1'b0, 32'h0, 32'h0, 1'b1, "verify secured");
        acc(pld_pkg::OFF_STATUS, 1'b0, 32'h0, 32'h0001_00f0, 1'b0, "status secured");
        acc(pld_pkg::OFF_SIG_LO, 1'b1, 32'h5a5a_a5a5, 32'h0, 1'b0, "sig write");
        acc(pld_pkg::OFF_SIG_LO, 1'b0, 32'h0, 32'h5a5a_a5a5, 1'b0, "sig lo");
        acc(pld_pkg::OFF_SIG_HI, 1'b0, 32'h0, 32'h0123_4567, 1'b0, "sig hi");
        $display("test security done");
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        #1;
        chk_pins("io_out reset", 10'h000, io_out);
        @(posedge pclk);
        presetn <= 1'b1;
        rel = cyc;
        wait_to(rel + 110);
        acc(pld_pkg::OFF_SIG_LO, 1'b0, 32'h0, 32'h0, 1'b0, "sig reset");
        acc(pld_pkg::OFF_STATUS, 1'b0, 32'h0, 32'h0000_00f0, 1'b0, "status reset");
        acc(pld_pkg::OFF_PRELOAD, 1'b1, 32'h0001_0001, 32'h0, 1'b0, "preload open");
        $display("test second_reset done");
        finish_test();
    end
endmodule : test_pld_regctl

`default_nettype wire
